//--- verif/core_ack_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Core side: vectors to the presented node after ack_gap cycles
// ----------------------------------------------------------------
module core_ack_model
  import irq_flag_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ack_on,
  input  wire logic [3:0]        ack_gap,
  input  wire logic              node_req,
  input  wire logic [NODE_W-1:0] node_sel,
  output logic      [NODES-1:0]  node_ack
);
  logic [3:0] wait_r;

  // One-cycle ack per vectoring; the wait restarts so a held request is acked again, as a core would
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_r   <= 4'h0;
      node_ack <= '0;
    end
    else
    begin
      node_ack <= '0;
      if (!ack_on || !node_req || (node_ack != '0))
        wait_r <= 4'h0;
      else if (wait_r < ack_gap)
        wait_r <= wait_r + 4'h1;
      else
      begin
        node_ack <= NODES'(1) << node_sel;
        wait_r   <= 4'h0;
      end
    end
  end
endmodule // core_ack_model

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import irq_flag_pkg::*;
;
  localparam logic [7:0] FO [5]  = '{OFS_FLAGS_ONE, OFS_FLAGS_TWO, OFS_FLAGS_THREE, OFS_FLAGS_FOUR, OFS_NMI};
  localparam logic [7:0] SWM [5] = '{8'h7f, 8'h09, 8'h33, 8'h33, 8'h6f};
  localparam logic [7:0] HWM [5] = '{8'h7f, 8'h09, 8'h33, 8'h33, 8'h67};
  localparam int         EVI [5] = '{0, 1, 2, 3, 6};
  localparam int         POS [4] = '{1, 5, 3, 7};
  localparam logic [5:0] PND [5] = '{6'h3f, 6'h3b, 6'h39, 6'h38, 6'h28};
  localparam logic [6:0] GNT [5] = '{7'h2b, 7'h26, 7'h21, 7'h31, 7'h2c};

  logic              pclk         = 1'b0;
  logic              presetn      = 1'b0;
  logic              cold_rst_n   = 1'b0;
  logic              psel         = 1'b0;
  logic              penable      = 1'b0;
  logic              pwrite       = 1'b0;
  logic [7:0]        paddr        = 8'h00;
  logic [31:0]       pwdata       = 32'h0;
  logic [7:0]        ev [7]       = '{default: 8'h00};
  logic [NODES-1:0]  node_pending = '0;
  logic              ack_on       = 1'b0;
  logic [3:0]        ack_gap      = 4'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [NODES-1:0]  node_ack;
  logic              nmi_req;
  logic              node_req;
  logic [NODE_W-1:0] node_sel;
  logic [1:0]        node_level;
  logic              irq;
  logic [31:0]       rd;
  logic              er;
  logic [7:0]        exp_b;
  int                err_count    = 0;
  int                num_checks   = 0;
  int                cyc          = 0;
  int                k;

  always #12.5 pclk = ~pclk;

  irq_flag_regs u_dut (.pclk(pclk), .presetn(presetn), .cold_rst_n(cold_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ev_flags_one(ev[0]), .ev_flags_two(ev[1]), .ev_flags_three(ev[2]), .ev_flags_four(ev[3]),
    .ev_ctr_ext(ev[4]), .ev_uart(ev[5]), .ev_nmi(ev[6]), .node_pending(node_pending), .node_ack(node_ack),
    .nmi_req(nmi_req), .node_req(node_req), .node_sel(node_sel), .node_level(node_level), .irq(irq));

  core_ack_model u_core (.pclk(pclk), .presetn(presetn), .ack_on(ack_on), .ack_gap(ack_gap),
    .node_req(node_req), .node_sel(node_sel), .node_ack(node_ack));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until pready is sampled high or 50 cycles pass; then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      err_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, e}, rd);
    chk({nm, "_err"}, 32'h0, {31'h0, er});
  endtask

  task automatic ev_set(input int i, input logic [7:0] v);
    @(posedge pclk);
    ev[i] <= v;
  endtask

  // Event stands until the clearing write's access edge and drops with it, so a lost set shows
  task automatic clash(input int i, input logic [7:0] a);
    fork
      wr(a, 8'h00);
      begin
        ev[i] <= 8'hff;
        @(posedge pclk iff (pready === 1'b1));
        ev[i] <= 8'h00;
      end
    join
  endtask

  task automatic grant(input string nm, input logic [6:0] e);
    repeat (3) @(posedge pclk);
    chk(nm, {25'h0, e}, {25'h0, nmi_req, node_req, node_sel, node_level});
  endtask

  task automatic rst_pulse(input logic cold);
    @(posedge pclk);
    if (cold)
      cold_rst_n <= 1'b0;
    else
      presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cold_rst_n <= 1'b1;
    presetn    <= 1'b1;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn    <= 1'b1;
    cold_rst_n <= 1'b1;
    for (int i = 0; i < 14; i++)
      if (i != 11)
        rdc("reset_value", 8'(4 * i), (i == 13) ? 8'h07 : 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(FO[i], SWM[i]);
      rdc("flag_sw_write", FO[i], SWM[i]);
      wr(FO[i], 8'h00);
      rdc("flag_sw_clear", FO[i], 8'h00);
      ev_set(EVI[i], 8'hff);
      ev_set(EVI[i], 8'h00);
      rdc("flag_hw_set", FO[i], HWM[i]);
      clash(EVI[i], FO[i]);
      rdc("hw_beats_sw", FO[i], HWM[i]);
      wr(FO[i], 8'h00);
    end
    // Plain storage bits must survive flag activity in the same byte
    wr(OFS_UART, 8'hfc);
    ev_set(5, 8'hff);
    ev_set(5, 8'h00);
    rdc("uart_flags", OFS_UART, 8'hff);
    wr(OFS_UART, 8'hfc);
    rdc("uart_sw_clear", OFS_UART, 8'hfc);
    wr(OFS_CTR_EXT, 8'h55);
    ev_set(4, 8'hff);
    ev_set(4, 8'h00);
    rdc("ctr_ext_set", OFS_CTR_EXT, 8'hff);
    wr(OFS_NODE_ENABLE, 8'h3f);
    ack_on <= 1'b1;
    exp_b = 8'hff;
    for (int n = 0; n < 4; n++)
    begin
      ack_gap      <= 4'(3 * n);
      node_pending <= NODES'(1) << n;
      for (k = 0; k < 60 && node_ack[n] !== 1'b1; k++)
        @(posedge pclk);
      node_pending <= '0;
      exp_b[POS[n]] = 1'b0;
      rdc("vector_clear", OFS_CTR_EXT, exp_b);
    end
    ack_on <= 1'b0;
    ev_set(4, 8'hff);
    ev_set(4, 8'h00);
    wr(OFS_CTR_EXT, 8'h55);
    rdc("ctr_ext_sw_clear", OFS_CTR_EXT, 8'h55);
    wr(OFS_LVL_LOW_A, 8'hff);
    rdc("level_low", OFS_LVL_LOW_A, 8'h3f);
    wr(OFS_LVL_HIGH_A, 8'hff);
    rdc("level_high", OFS_LVL_HIGH_A, 8'h3f);
    wr(OFS_LVL_LOW_A, 8'h15);
    wr(OFS_LVL_HIGH_A, 8'h06);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge pclk);
      node_pending <= PND[i];
      grant("winner", GNT[i]);
    end
    wr(OFS_NODE_ENABLE, 8'h3b);
    node_pending <= 6'h3f;
    grant("winner_enabled", 7'h26);
    rdc("grant_reg", OFS_GRANT, 8'h61);
    ev_set(6, 8'h01);
    ev_set(6, 8'h00);
    repeat (3) @(posedge pclk);
    chk("nmi_over_node", 32'h2, {30'h0, nmi_req, node_req});
    node_pending <= '0;
    rst_pulse(1'b0);
    rdc("nmi_warm_keep", OFS_NMI, 8'h01);
    rdc("enable_warm", OFS_NODE_ENABLE, 8'h00);
    rst_pulse(1'b1);
    rdc("nmi_cold_clear", OFS_NMI, 8'h00);
    wr(OFS_IRQ_CLEAR, 8'h0f);
    rdc("status_idle", OFS_IRQ_STATUS, 8'h00);
    ev_set(5, 8'h01);
    ev_set(5, 8'h00);
    rdc("status_uart", OFS_IRQ_STATUS, 8'h08);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_ENABLE, 8'h08);
    rdc("irq_enable", OFS_IRQ_ENABLE, 8'h08);
    chk("irq_raised", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_STATUS, 8'h00);
    rdc("status_ro", OFS_IRQ_STATUS, 8'h08);
    wr(OFS_UART, 8'h00);
    wr(OFS_IRQ_CLEAR, 8'h08);
    rdc("status_cleared", OFS_IRQ_STATUS, 8'h00);
    chk("irq_dropped", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h3c, 32'hff);
    chk("unmapped_wr_err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped_rd", 32'h1, {rd[30:0], er});
    finish_test();
  end
endmodule // tb_top

//--- verilog/irq_flag_pkg.sv
package irq_flag_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS_ONE   = 8'h00;
  localparam logic [7:0] OFS_FLAGS_TWO   = 8'h04;
  localparam logic [7:0] OFS_FLAGS_THREE = 8'h08;
  localparam logic [7:0] OFS_FLAGS_FOUR  = 8'h0c;
  localparam logic [7:0] OFS_CTR_EXT     = 8'h10;
  localparam logic [7:0] OFS_UART        = 8'h14;
  localparam logic [7:0] OFS_NMI         = 8'h18;
  localparam logic [7:0] OFS_LVL_LOW_A   = 8'h1c;
  localparam logic [7:0] OFS_LVL_HIGH_A  = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h28;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h2c;
  localparam logic [7:0] OFS_NODE_ENABLE = 8'h30;
  localparam logic [7:0] OFS_GRANT       = 8'h34;

  // ----------------------------------------------------------------
  // Implemented-bit masks (reserved bits read zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] MSK_FLAGS_ONE   = 8'h7f;
  localparam logic [7:0] MSK_FLAGS_TWO   = 8'h09;
  localparam logic [7:0] MSK_FLAGS_THREE = 8'h33;
  localparam logic [7:0] MSK_FLAGS_FOUR  = 8'h33;
  localparam logic [7:0] MSK_CTR_EXT_HW  = 8'haa;
  localparam logic [7:0] MSK_UART_HW     = 8'h03;
  localparam logic [7:0] MSK_NMI         = 8'h6f;
  localparam logic [7:0] MSK_NMI_HW      = 8'h67;
  localparam logic [7:0] MSK_LEVEL       = 8'h3f;
  localparam logic [7:0] RST_BYTE        = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_EXT0 = 1;
  localparam int POS_EXT1 = 3;
  localparam int POS_CTR0 = 5;
  localparam int POS_CTR1 = 7;
  localparam int POS_URX  = 0;
  localparam int POS_UTX  = 1;

  localparam int NODES     = 6;
  localparam int NODE_W    = 3;
  localparam int EVENTS    = 4;
  localparam logic [NODE_W-1:0] NODE_NONE = 3'h7;

endpackage : irq_flag_pkg

//--- verilog/irq_flag_regs.sv
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module irq_flag_regs
  import irq_flag_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              cold_rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        ev_flags_one,
  input  wire logic [7:0]        ev_flags_two,
  input  wire logic [7:0]        ev_flags_three,
  input  wire logic [7:0]        ev_flags_four,
  input  wire logic [7:0]        ev_ctr_ext,
  input  wire logic [7:0]        ev_uart,
  input  wire logic [7:0]        ev_nmi,
  input  wire logic [NODES-1:0]  node_pending,
  input  wire logic [NODES-1:0]  node_ack,
  output logic                   nmi_req,
  output logic                   node_req,
  output logic      [NODE_W-1:0] node_sel,
  output logic      [1:0]        node_level,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wdat;
  logic       hit;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wdat  = pwdata[7:0];

  logic we_one, we_two, we_three, we_four, we_ctr, we_uart, we_nmi;
  logic we_lo, we_hi, we_ien, we_iclr, we_nen;
  assign we_one   = wr_en & (paddr == OFS_FLAGS_ONE);
  assign we_two   = wr_en & (paddr == OFS_FLAGS_TWO);
  assign we_three = wr_en & (paddr == OFS_FLAGS_THREE);
  assign we_four  = wr_en & (paddr == OFS_FLAGS_FOUR);
  assign we_ctr   = wr_en & (paddr == OFS_CTR_EXT);
  assign we_uart  = wr_en & (paddr == OFS_UART);
  assign we_nmi   = wr_en & (paddr == OFS_NMI);
  assign we_lo    = wr_en & (paddr == OFS_LVL_LOW_A);
  assign we_hi    = wr_en & (paddr == OFS_LVL_HIGH_A);
  assign we_ien   = wr_en & (paddr == OFS_IRQ_ENABLE);
  assign we_iclr  = wr_en & (paddr == OFS_IRQ_CLEAR);
  assign we_nen   = wr_en & (paddr == OFS_NODE_ENABLE);

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  logic [7:0] f_one, f_two, f_three, f_four, f_ctr, f_uart, f_nmi;
  logic [7:0] ctr_vec_clr;
  logic [7:0] no_clr;
  assign no_clr = RST_BYTE;

  // Vectoring to a node clears its counter/external flag
  assign ctr_vec_clr = {node_ack[3], 1'b0, node_ack[1], 1'b0,
                        node_ack[2], 1'b0, node_ack[0], 1'b0};

  sticky_byte #(.MASK(MSK_FLAGS_ONE)) u_one
  (
    .pclk    (pclk),
    .rst_n   (presetn),
    .hw_set  (ev_flags_one),
    .hw_clr  (no_clr),
    .sw_we   (we_one),
    .sw_data (wdat),
    .flags   (f_one)
  );

  sticky_byte #(.MASK(MSK_FLAGS_TWO)) u_two
  (
    .pclk    (pclk),
    .rst_n   (presetn),
    .hw_set  (ev_flags_two),
    .hw_clr  (no_clr),
    .sw_we   (we_two),
    .sw_data (wdat),
    .flags   (f_two)
  );

  sticky_byte #(.MASK(MSK_FLAGS_THREE)) u_three
  (
    .pclk    (pclk),
    .rst_n   (presetn),
    .hw_set  (ev_flags_three),
    .hw_clr  (no_clr),
    .sw_we   (we_three),
    .sw_data (wdat),
    .flags   (f_three)
  );

  sticky_byte #(.MASK(MSK_FLAGS_FOUR)) u_four
  (
    .pclk    (pclk),
    .rst_n   (presetn),
    .hw_set  (ev_flags_four),
    .hw_clr  (no_clr),
    .sw_we   (we_four),
    .sw_data (wdat),
    .flags   (f_four)
  );

  // Control bits of the counter register are plain storage
  logic [7:0] ctr_ctl_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctr_ctl_r <= RST_BYTE;
    else if (we_ctr)
      ctr_ctl_r <= wdat & ~MSK_CTR_EXT_HW;
  end

  sticky_byte #(.MASK(MSK_CTR_EXT_HW)) u_ctr
  (
    .pclk    (pclk),
    .rst_n   (presetn),
    .hw_set  (ev_ctr_ext),
    .hw_clr  (ctr_vec_clr),
    .sw_we   (we_ctr),
    .sw_data (wdat),
    .flags   (f_ctr)
  );

  logic [7:0] uart_ctl_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      uart_ctl_r <= RST_BYTE;
    else if (we_uart)
      uart_ctl_r <= wdat & ~MSK_UART_HW;
  end

  sticky_byte #(.MASK(MSK_UART_HW)) u_uart
  (
    .pclk    (pclk),
    .rst_n   (presetn),
    .hw_set  (ev_uart),
    .hw_clr  (no_clr),
    .sw_we   (we_uart),
    .sw_data (wdat),
    .flags   (f_uart)
  );

  // Debug bit has no hardware source here: its set state is reserved
  sticky_byte #(.MASK(MSK_NMI)) u_nmi
  (
    .pclk    (pclk),
    .rst_n   (cold_rst_n),
    .hw_set  (ev_nmi & MSK_NMI_HW),
    .hw_clr  (no_clr),
    .sw_we   (we_nmi),
    .sw_data (wdat),
    .flags   (f_nmi)
  );

  // ----------------------------------------------------------------
  // Level registers and node enables
  // ----------------------------------------------------------------
  logic [7:0] lvl_lo_r;
  logic [7:0] lvl_hi_r;
  logic [7:0] node_en_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl_lo_r  <= RST_BYTE;
      lvl_hi_r  <= RST_BYTE;
      node_en_r <= RST_BYTE;
    end
    else
    begin
      if (we_lo)
        lvl_lo_r <= wdat & MSK_LEVEL;
      if (we_hi)
        lvl_hi_r <= wdat & MSK_LEVEL;
      if (we_nen)
        node_en_r <= wdat & MSK_LEVEL;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [NODES-1:0] req_vec;
  logic [NODE_W-1:0] win_nxt;
  logic [1:0]       win_lvl_nxt;
  logic             win_any_nxt;
  logic             nmi_any;
  assign req_vec = node_pending & node_en_r[NODES-1:0];
  assign nmi_any = |f_nmi;

  always_comb
  begin
    win_nxt     = NODE_NONE;
    win_lvl_nxt = 2'h0;
    win_any_nxt = 1'b0;
    // Walk downward so an equal level at a lower node takes over
    for (int i = NODES - 1; i >= 0; i--)
    begin
      if (req_vec[i] && (!win_any_nxt || {lvl_hi_r[i], lvl_lo_r[i]} >= win_lvl_nxt))
      begin
        win_nxt     = NODE_W'(i);
        win_lvl_nxt = {lvl_hi_r[i], lvl_lo_r[i]};
        win_any_nxt = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status (sticky), enable, clear
  // ----------------------------------------------------------------
  logic [EVENTS-1:0] ev_vec;
  logic [EVENTS-1:0] ist_r;
  logic [EVENTS-1:0] ien_r;
  assign ev_vec = {|(ev_uart & MSK_UART_HW), |(ev_ctr_ext & MSK_CTR_EXT_HW),
                   |(ev_nmi & MSK_NMI_HW),
                   |{ev_flags_one, ev_flags_two, ev_flags_three, ev_flags_four}};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ist_r <= '0;
      ien_r <= '0;
    end
    else
    begin
      // New event wins over a simultaneous clear
      ist_r <= ev_vec | (ist_r & ~({EVENTS{we_iclr}} & wdat[EVENTS-1:0]));
      if (we_ien)
        ien_r <= wdat[EVENTS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_req    <= 1'b0;
      node_req   <= 1'b0;
      node_sel   <= NODE_NONE;
      node_level <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      nmi_req    <= nmi_any;
      node_req   <= win_any_nxt & ~nmi_any;
      node_sel   <= win_nxt;
      node_level <= win_lvl_nxt;
      irq        <= |(ist_r & ien_r);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb
  begin
    hit     = 1'b1;
    rd_byte = RST_BYTE;
    unique case (paddr)
      OFS_FLAGS_ONE   : rd_byte = f_one;
      OFS_FLAGS_TWO   : rd_byte = f_two;
      OFS_FLAGS_THREE : rd_byte = f_three;
      OFS_FLAGS_FOUR  : rd_byte = f_four;
      OFS_CTR_EXT     : rd_byte = f_ctr | ctr_ctl_r;
      OFS_UART        : rd_byte = f_uart | uart_ctl_r;
      OFS_NMI         : rd_byte = f_nmi;
      OFS_LVL_LOW_A   : rd_byte = lvl_lo_r;
      OFS_LVL_HIGH_A  : rd_byte = lvl_hi_r;
      OFS_IRQ_STATUS  : rd_byte = {4'h0, ist_r};
      OFS_IRQ_ENABLE  : rd_byte = {4'h0, ien_r};
      OFS_IRQ_CLEAR   : rd_byte = RST_BYTE;
      OFS_NODE_ENABLE : rd_byte = node_en_r;
      OFS_GRANT       : rd_byte = {nmi_req, node_req, node_level, 1'b0, node_sel};
      default         : hit = 1'b0;
    endcase
  end

  // Zero-wait slave; unmapped offsets answer with an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel & ~penable & ~pwrite)
      prdata <= {24'h0, rd_byte};
  end

  logic err_nxt;
  assign err_nxt = psel & ~penable & ~hit;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= err_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    ((f_two & ~MSK_FLAGS_TWO) == 8'h00) && ((f_one & ~MSK_FLAGS_ONE) == 8'h00))
    else $error("reserved flag bit set");
  AST_SET_STICKS: assert property (@(posedge pclk) disable iff (!presetn)
    ev_flags_three[0] |=> f_three[0])
    else $error("event did not set flag");
  AST_HW_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (we_one && ev_flags_one[2]) |=> f_one[2])
    else $error("software write beat hardware set");
  AST_NO_HW_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (f_uart[POS_URX] && !we_uart) |=> f_uart[POS_URX])
    else $error("uart flag lost without write");
  AST_VEC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (node_ack[1] && !ev_ctr_ext[POS_CTR0] && !we_ctr) |=> !f_ctr[POS_CTR0])
    else $error("overflow flag kept after vectoring");
  AST_EXT_SET: assert property (@(posedge pclk) disable iff (!presetn)
    ev_ctr_ext[POS_EXT1] |=> f_ctr[POS_EXT1])
    else $error("external flag not set");
  AST_NMI_OVER: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_req |-> !node_req)
    else $error("node request beside nmi");
  AST_NMI_KEEP: assert property (@(posedge pclk) disable iff (!cold_rst_n)
    (f_nmi[0] && !we_nmi) |=> f_nmi[0])
    else $error("nmi cause lost");
  AST_LEVEL_WIN: assert property (@(posedge pclk) disable iff (!presetn)
    (win_any_nxt && req_vec[0]) |-> (win_lvl_nxt >= {lvl_hi_r[0], lvl_lo_r[0]}))
    else $error("lower level won arbitration");

endmodule // irq_flag_regs

//--- verilog/sticky_byte.sv
`timescale 1ns/100ps
// Sticky flag byte: hardware set beats software clear and hardware clear.
module sticky_byte
  import irq_flag_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
)
(
  input  wire logic       pclk,
  input  wire logic       rst_n,
  input  wire logic [7:0] hw_set,
  input  wire logic [7:0] hw_clr,
  input  wire logic       sw_we,
  input  wire logic [7:0] sw_data,
  output logic      [7:0] flags
);

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // Written value only lands on bits hardware is not setting
  assign flags_nxt = MASK & (hw_set | ((sw_we ? sw_data : flags_r) & ~hw_clr));
  assign flags     = flags_r;

  always_ff @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
      flags_r <= RST_BYTE;
    else
      flags_r <= flags_nxt;
  end

endmodule // sticky_byte
